// >>> inc/bwm_pkg.sv
package bwm_pkg;
  // ****************************************
  // Widths and ranges
  // ****************************************
  localparam int          BWM_CUR_W         = 16;   // Per-sample current magnitude
  localparam int          BWM_ACC_W         = 40;   // Running wear total
  localparam int          BWM_DLY_W         = 16;   // Tenths of a cycle, up to 40959
  localparam int          BWM_TCD_W         = 14;   // Trip path delay, whole cycles
  localparam int          BWM_SPC_W         = 8;    // Samples per power cycle
  localparam int          BWM_NPH           = 3;
  localparam logic [15:0] BWM_DLY_MAX       = 16'h9FFF; // 4095.9 cycles in tenths
  localparam logic [39:0] BWM_PRESET_MAX    = 40'h000000C350; // 50000
  localparam logic [3:0]  BWM_STOP_CYCLES   = 4'hA; // Longest integration, cycles
  localparam logic [7:0]  BWM_DROP_PCT      = 8'h0A; // Stop below 10 % nominal
  localparam logic [7:0]  BWM_PCT_FULL      = 8'h64;
  localparam logic [13:0] BWM_TCD_MAX       = 14'h1FE0; // 8160 cycles
  localparam logic [3:0]  BWM_TENTH_DIV     = 4'hA;
endpackage

// >>> logic/bwm_phase_acc.sv
`timescale 1ns/1ps
module bwm_phase_acc
  import bwm_pkg::*;
(
  input  wire logic                 sys_clk_in,      // System clock
  input  wire logic                 reset_in,        // Sync reset, high
  input  wire logic                 integ_in,        // Integration window open
  input  wire logic                 sample_in,       // Sample strobe
  input  wire logic                 done_in,         // Interruption finished
  input  wire logic                 squared_in,      // 1: current squared
  input  wire logic [BWM_CUR_W-1:0] cur_in,          // Phase current
  input  wire logic                 preset_in,       // Load preset
  input  wire logic [BWM_ACC_W-1:0] preset_val_in,   // Preset value
  input  wire logic [BWM_ACC_W-1:0] thresh_in,       // Threshold
  output logic      [BWM_ACC_W-1:0] total_out,       // Running total
  output logic                      over_out         // Total above threshold
);
  typedef struct packed {
    logic [BWM_ACC_W-1:0] part;
    logic [BWM_ACC_W-1:0] total;
  } bwm_acc_type;

  bwm_acc_type s_q;
  bwm_acc_type s_d;
  logic [BWM_ACC_W-1:0] incr;
  logic [BWM_ACC_W-1:0] pv;

  always_comb begin
    s_d = s_q;
    incr = squared_in ? BWM_ACC_W'(cur_in * cur_in) : BWM_ACC_W'(cur_in);
    pv = (preset_val_in > BWM_PRESET_MAX) ? BWM_PRESET_MAX : preset_val_in;
    if (integ_in && sample_in) begin
      s_d.part = s_q.part + incr;
    end
    if (done_in) begin
      s_d.total = s_q.total + s_q.part;
      s_d.part = '0;
    end
    if (preset_in) begin
      s_d.total = pv;
      s_d.part = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign total_out = s_q.total;
  assign over_out = s_q.total > thresh_in;
endmodule

// >>> logic/bwm_monitor.sv
`timescale 1ns/1ps
// Behaviour
// - Per phase, integrate current or current squared, method chosen by a setting.
// - At interruption end add each phase's new wear to its own total.
// - Compare every total to one threshold; any phase above drives the output.
// - Each phase's running total is readable as an actual value.
// - Integration starts after a settable delay from trip initiate, to 4095.9 cycles.
// - Integration stops at current below 10% nominal or after 10 cycles.
// - Each total accepts a preset from 0 to 50000 via the config path.
// - Supervision input active means contact open and trip circuit continuous.
// - Contact open with input inactive means open circuit or welded contact.
// - Trip commanded closed but input still active means contact failed to close.
// - Supervision blocked while breaker-open auxiliary shows breaker open.
// - Supervision blocked by lockout-tripped contact input when lockout supervised.
// - Supervision result can be routed to an output as maintenance alarm.
module bwm_monitor
  import bwm_pkg::*;
#(
  parameter int SAMPLES_PER_CYCLE = 16  // Sample strobes per power cycle
)(
  input  wire logic                 sys_clk_in,        // System clock 50 MHz
  input  wire logic                 reset_in,          // Sync reset, high
  input  wire logic                 sample_in,         // Current sample strobe
  input  wire logic [BWM_CUR_W-1:0] cur_a_in,          // Phase A current
  input  wire logic [BWM_CUR_W-1:0] cur_b_in,          // Phase B current
  input  wire logic [BWM_CUR_W-1:0] cur_c_in,          // Phase C current
  input  wire logic [BWM_CUR_W-1:0] nominal_in,        // Nominal current setting
  input  wire logic                 trip_initiate_in,  // Trip initiate pulse
  input  wire logic                 wear_enable_in,    // Wear monitor enabled
  input  wire logic                 squared_sel_in,    // 1: current squared integral
  input  wire logic [BWM_DLY_W-1:0] wear_delay_in,     // Start delay, tenths of cycle
  input  wire logic [BWM_ACC_W-1:0] wear_thresh_in,    // Wear pickup
  input  wire logic                 preset_load_in,    // Config path preset strobe
  input  wire logic [BWM_ACC_W-1:0] preset_a_in,       // Phase A preset
  input  wire logic [BWM_ACC_W-1:0] preset_b_in,       // Phase B preset
  input  wire logic [BWM_ACC_W-1:0] preset_c_in,       // Phase C preset
  input  wire logic [7:0]           block_in,          // Blocking inputs
  input  wire logic [7:0]           wear_block_sel_in, // Blocks for wear output
  input  wire logic [7:0]           tc_block_sel_in,   // Blocks for supervision
  input  wire logic                 tc_enable_in,      // Supervision enabled
  input  wire logic                 supervision_in,    // Trip path check input
  input  wire logic                 trip_cmd_in,       // Trip contact commanded closed
  input  wire logic                 breaker_open_input_in, // Breaker aux open contact
  input  wire logic                 lockout_tripped_in, // Lockout relay tripped
  input  wire logic                 lockout_sup_in,    // Supervising a lockout relay
  input  wire logic [BWM_TCD_W-1:0] tc_delay_in,       // Alarm delay, cycles
  output logic      [BWM_ACC_W-1:0] total_a_out,       // Phase A total
  output logic      [BWM_ACC_W-1:0] total_b_out,       // Phase B total
  output logic      [BWM_ACC_W-1:0] total_c_out,       // Phase C total
  output logic                      integrating_out,   // Integration window open
  output logic                      wear_alarm_out,    // Wear threshold output
  output logic                      tc_alarm_out,      // Supervision alarm
  output logic                      tc_open_out,       // Open circuit or welded
  output logic                      tc_noclose_out     // Contact failed to close
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_INTEG = 3'b100
  } bwm_state_type;

  typedef struct packed {
    bwm_state_type        st;
    logic [BWM_DLY_W-1:0] dly;       // Tenths elapsed
    logic [BWM_SPC_W-1:0] spc;       // Samples within cycle
    logic [3:0]           tenth_cnt; // Samples within tenth (approximate)
    logic [3:0]           icyc;      // Integration cycles
    logic                 done;
    logic [BWM_SPC_W-1:0] tspc;
    logic [BWM_TCD_W-1:0] tcd;
    logic                 tca;
    logic                 tco;
    logic                 tcn;
    logic                 wal;
  } bwm_state_reg_type;

  bwm_state_reg_type s_q;
  bwm_state_reg_type s_d;

  logic                 cyc_tick;
  logic                 tenth_tick;
  logic                 low_all;
  logic                 tc_block;
  logic                 wear_block;
  logic                 tc_fail;
  logic [2:0]           over;
  logic [BWM_CUR_W+7:0] lim;
  logic [BWM_DLY_W-1:0] dly_set;

  // ****************************************
  // Per-phase accumulators
  // ****************************************
  logic [BWM_CUR_W-1:0] cur [BWM_NPH];
  logic [BWM_ACC_W-1:0] pre [BWM_NPH];
  logic [BWM_ACC_W-1:0] tot [BWM_NPH];
  assign cur[0] = cur_a_in;
  assign cur[1] = cur_b_in;
  assign cur[2] = cur_c_in;
  assign pre[0] = preset_a_in;
  assign pre[1] = preset_b_in;
  assign pre[2] = preset_c_in;

  // Phases share timing so one interruption closes all three totals together
  for (genvar p = 0; p < BWM_NPH; p++) begin : g_ph
    bwm_phase_acc u_acc (
      .sys_clk_in    (sys_clk_in),
      .reset_in      (reset_in),
      .integ_in      (s_q.st == ST_INTEG),
      .sample_in     (sample_in),
      .done_in       (s_q.done),
      .squared_in    (squared_sel_in),
      .cur_in        (cur[p]),
      .preset_in     (preset_load_in),
      .preset_val_in (pre[p]),
      .thresh_in     (wear_thresh_in),
      .total_out     (tot[p]),
      .over_out      (over[p])
    );
  end

  // ****************************************
  // Timing and supervision
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    dly_set = (wear_delay_in > BWM_DLY_MAX) ? BWM_DLY_MAX : wear_delay_in;
    cyc_tick = sample_in && (s_q.spc == BWM_SPC_W'(SAMPLES_PER_CYCLE - 1));
    // Tenth ticks approximate with whole samples; limited by sample rate
    tenth_tick = sample_in && (s_q.tenth_cnt >= 4'(SAMPLES_PER_CYCLE / 10 - 1)
                 || SAMPLES_PER_CYCLE < 10);
    lim = BWM_CUR_W'(nominal_in) * BWM_DROP_PCT;
    low_all = 1'b1;
    for (int i = 0; i < BWM_NPH; i++) begin
      if ((BWM_CUR_W+8)'(cur[i]) * BWM_PCT_FULL >= (BWM_CUR_W+8)'(lim)) begin
        low_all = 1'b0;
      end
    end
    if (sample_in) begin
      s_d.spc = cyc_tick ? '0 : s_q.spc + 1'b1;
      s_d.tenth_cnt = tenth_tick ? '0 : s_q.tenth_cnt + 1'b1;
    end

    // ****************************************
    // Interruption timing
    // ****************************************
    unique case (s_q.st)
      ST_IDLE: begin
        if (trip_initiate_in && wear_enable_in) begin
          s_d.st = ST_DELAY;
          s_d.dly = '0;
        end
      end
      ST_DELAY: begin
        if (s_q.dly >= dly_set) begin
          s_d.st = ST_INTEG;
          s_d.icyc = '0;
        end else if (tenth_tick) begin
          s_d.dly = s_q.dly + 1'b1;
        end
      end
      ST_INTEG: begin
        // Stop test uses the sample that is integrated in this same cycle
        if (cyc_tick) begin
          s_d.icyc = s_q.icyc + 1'b1;
        end
        if ((sample_in && low_all) || (cyc_tick && s_q.icyc == BWM_STOP_CYCLES - 1'b1)) begin
          s_d.st = ST_IDLE;
          s_d.done = 1'b1;
        end
      end
    endcase

    // ****************************************
    // Trip path supervision
    // ****************************************
    // Breaker open masks the check: no coil current can flow then
    tc_block = (breaker_open_input_in)
             || (lockout_sup_in && lockout_tripped_in)
             || |(block_in & tc_block_sel_in);
    wear_block = |(block_in & wear_block_sel_in);
    s_d.tco = !trip_cmd_in && !supervision_in && !tc_block;
    s_d.tcn = trip_cmd_in && supervision_in && !tc_block;
    tc_fail = tc_enable_in && (s_d.tco || s_d.tcn);
    s_d.tspc = (sample_in && s_q.tspc == BWM_SPC_W'(SAMPLES_PER_CYCLE - 1)) ? '0
             : (sample_in ? s_q.tspc + 1'b1 : s_q.tspc);
    // Delay counted in whole cycles; any gap in the fault restarts it
    if (!tc_fail) begin
      s_d.tcd = '0;
      s_d.tca = 1'b0;
    end else if (s_q.tcd >= tc_delay_in) begin
      s_d.tca = 1'b1;
    end else if (sample_in && s_q.tspc == BWM_SPC_W'(SAMPLES_PER_CYCLE - 1)) begin
      s_d.tcd = s_q.tcd + 1'b1;
    end
    s_d.wal = |over && wear_enable_in && !wear_block;
  end

  // ****************************************
  // Registers
  // ****************************************
  // One state register keeps reset handling in a single place
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_q <= '{st: ST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Alarm and fault flags come straight from flops, so contacts never see glitches
  assign total_a_out = tot[0];
  assign total_b_out = tot[1];
  assign total_c_out = tot[2];
  assign integrating_out = (s_q.st == ST_INTEG);
  assign wear_alarm_out = s_q.wal;
  assign tc_alarm_out = s_q.tca;
  assign tc_open_out = s_q.tco;
  assign tc_noclose_out = s_q.tcn;
endmodule

// >>> tb/bwm_monitor_checker.sv
`timescale 1ns/1ps
module bwm_monitor_checker
  import bwm_pkg::*;
#(
  parameter int SAMPLES_PER_CYCLE = 16
)(
  input wire logic                 sys_clk_in,
  input wire logic                 reset_in,
  input wire logic                 sample_in,
  input wire logic                 preset_load_in,
  input wire logic [BWM_ACC_W-1:0] preset_a_in,
  input wire logic [7:0]           block_in,
  input wire logic [7:0]           wear_block_sel_in,
  input wire logic [7:0]           tc_block_sel_in,
  input wire logic                 tc_enable_in,
  input wire logic                 supervision_in,
  input wire logic                 trip_cmd_in,
  input wire logic                 breaker_open_input_in,
  input wire logic                 lockout_tripped_in,
  input wire logic                 lockout_sup_in,
  input wire logic [BWM_ACC_W-1:0] total_a_out,
  input wire logic                 integrating_out,
  input wire logic                 wear_alarm_out,
  input wire logic                 tc_alarm_out,
  input wire logic                 tc_open_out,
  input wire logic                 tc_noclose_out
);
  logic [9:0] n_q;
  logic [9:0] n_d;
  wire logic  hold = breaker_open_input_in || (lockout_tripped_in && lockout_sup_in);
  wire logic  tblk = |(block_in & tc_block_sel_in);
  wire logic  wblk = |(block_in & wear_block_sel_in);
  wire logic  tc_ok = tc_enable_in && !hold && !tblk;
  // Samples taken inside one integration window
  always_comb n_d = integrating_out ? n_q + {9'h000, sample_in} : 10'h000;
  always_ff @(posedge sys_clk_in) n_q <= reset_in ? 10'h000 : n_d;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_open; tc_ok && !supervision_in && !trip_cmd_in; endsequence
  sequence s_noclose; tc_ok && supervision_in && trip_cmd_in; endsequence
  sequence s_quiet; !tc_open_out && !tc_noclose_out; endsequence
  chk_reset_clear: assert property (disable iff (1'b0) reset_in |=> !integrating_out &&
    !wear_alarm_out && !tc_alarm_out && total_a_out == '0) else $error("reset left outputs set");
  chk_open_flag: assert property (s_open |=> tc_open_out)
    else $error("open trip path not flagged");
  chk_noclose_flag: assert property (s_noclose |=> tc_noclose_out)
    else $error("failed close not flagged");
  chk_hold_quiet: assert property (hold ##1 hold |-> !tc_alarm_out && !tc_open_out &&
    !tc_noclose_out) else $error("supervision not blocked");
  chk_tc_mask: assert property (tblk ##1 tblk |-> !tc_alarm_out)
    else $error("blocked trip path alarm");
  chk_wear_mask: assert property (wblk ##1 wblk |-> !wear_alarm_out)
    else $error("blocked wear alarm");
  chk_alarm_clear: assert property (s_quiet [*3] |-> !tc_alarm_out)
    else $error("alarm without failure");
  chk_preset_load: assert property (preset_load_in |=> total_a_out ==
    (($past(preset_a_in) > BWM_PRESET_MAX) ? BWM_PRESET_MAX : $past(preset_a_in)))
    else $error("preset not loaded");
  chk_total_source: assert property (!$stable(total_a_out) |-> $past(reset_in) ||
    $past(preset_load_in) || $past(integrating_out) || $past(integrating_out, 2) ||
    $past(integrating_out, 3)) else $error("total moved outside interruption end");
  chk_integ_len: assert property (n_q <= 10 * SAMPLES_PER_CYCLE + 2)
    else $error("integration ran past ten cycles");
endmodule

bind bwm_monitor bwm_monitor_checker #(.SAMPLES_PER_CYCLE(SAMPLES_PER_CYCLE)) u_chk (
  .sys_clk_in, .reset_in, .sample_in, .preset_load_in, .preset_a_in, .block_in,
  .wear_block_sel_in, .tc_block_sel_in, .tc_enable_in, .supervision_in, .trip_cmd_in,
  .breaker_open_input_in, .lockout_tripped_in, .lockout_sup_in, .total_a_out,
  .integrating_out, .wear_alarm_out, .tc_alarm_out, .tc_open_out, .tc_noclose_out
);

// >>> tb/bwm_breaker_model.sv
`timescale 1ns/1ps
module bwm_breaker_model (
  input  wire logic trip_cmd_in,     // Trip contact commanded closed
  input  wire logic path_open_in,    // Coil circuit broken
  input  wire logic welded_in,       // Trip contact welded shut
  input  wire logic stuck_in,        // Trip contact never closes
  output logic      supervision_out, // Current through check input
  output logic      breaker_open_out // Auxiliary open contact
);
  wire logic shut = welded_in || (trip_cmd_in && !stuck_in);
  // A shut contact bypasses the check input, so no current either way
  assign supervision_out = !path_open_in && !shut;
  // Breaker parts slowly, so the relay sees the trip before the block
  assign #100 breaker_open_out = trip_cmd_in && !stuck_in && !path_open_in;
endmodule

// >>> tb/tb_bwm_monitor.sv
`timescale 1ns/1ps
module tb_bwm_monitor;
  import bwm_pkg::*;
  localparam int SPC = 4;
  logic sys_clk_in = 1'b0, reset_in = 1'b1, sample_in = 1'b0, trip_initiate_in = 1'b0;
  logic wear_enable_in = 1'b1, squared_sel_in = 1'b0, preset_load_in = 1'b0, tc_enable_in = 1'b1;
  logic trip_cmd_in = 1'b0, lockout_tripped_in = 1'b0, lockout_sup_in = 1'b1, path_open = 1'b0;
  logic welded = 1'b0, stuck = 1'b0, supervision_in, breaker_open_input_in, integrating_out;
  logic wear_alarm_out, tc_alarm_out, tc_open_out, tc_noclose_out;
  logic [15:0] cur_a_in = '0, cur_b_in = '0, cur_c_in = '0, nominal_in = 16'h0064;
  logic [15:0] wear_delay_in = '0, lfsr = 16'h3BDC;
  logic [39:0] wear_thresh_in = '1, preset_a_in = '0, preset_b_in = '0, preset_c_in = '0;
  logic [39:0] total_a_out, total_b_out, total_c_out;
  logic [7:0]  block_in = '0, wear_block_sel_in = 8'h01, tc_block_sel_in = 8'h02;
  logic [13:0] tc_delay_in = 14'h0002;
  logic [9:0]  tcs [7] = '{10'h010, 10'h205, 10'h115, 10'h0D3, 10'h050, 10'h230, 10'h225};
  int          fail_count = 0, checks_done = 0, nsamp = 0;
  longint      exp_tot [3] = '{0, 0, 0};
  longint      mx = 0;
  bwm_monitor #(.SAMPLES_PER_CYCLE(SPC)) dut (
    .sys_clk_in, .reset_in, .sample_in, .cur_a_in, .cur_b_in, .cur_c_in, .nominal_in,
    .trip_initiate_in, .wear_enable_in, .squared_sel_in, .wear_delay_in, .wear_thresh_in,
    .preset_load_in, .preset_a_in, .preset_b_in, .preset_c_in, .block_in, .wear_block_sel_in,
    .tc_block_sel_in, .tc_enable_in, .supervision_in, .trip_cmd_in, .breaker_open_input_in,
    .lockout_tripped_in, .lockout_sup_in, .tc_delay_in, .total_a_out, .total_b_out,
    .total_c_out, .integrating_out, .wear_alarm_out, .tc_alarm_out, .tc_open_out, .tc_noclose_out
  );
  bwm_breaker_model u_brk (.trip_cmd_in(trip_cmd_in), .path_open_in(path_open),
    .welded_in(welded), .stuck_in(stuck), .supervision_out(supervision_in),
    .breaker_open_out(breaker_open_input_in));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic longint wear(input logic [15:0] c);
    return squared_sel_in ? longint'(c) * c : longint'(c);
  endfunction
  function automatic longint clampf(input logic [39:0] v);
    return (v > BWM_PRESET_MAX) ? longint'(BWM_PRESET_MAX) : longint'(v);
  endfunction
  task automatic chk(input logic [39:0] seen, want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tot_chk;
    repeat (3) @(posedge sys_clk_in);
    #2 chk(total_a_out, exp_tot[0][39:0]);
    chk(total_b_out, exp_tot[1][39:0]);
    chk(total_c_out, exp_tot[2][39:0]);
  endtask
  task automatic wait_for(input logic v);
    int i;
    for (i = 0; i < 2000 && integrating_out !== v; i++) begin
      @(posedge sys_clk_in);
      #2;
    end
    if (i == 2000) begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic run(input logic sq, input logic [15:0] dly, input logic drop);
    @(posedge sys_clk_in);
    #1 lfsr = nx(lfsr);
    {squared_sel_in, wear_delay_in, nsamp} = {sq, dly, 32'h0};
    {cur_a_in, cur_b_in, cur_c_in} = {1'b1, lfsr[14:0], 1'b1, lfsr[7:0], lfsr[14:8], 16'h8000};
    trip_initiate_in = 1'b1;
    @(posedge sys_clk_in);
    #1 trip_initiate_in = 1'b0;
    repeat (8) @(posedge sys_clk_in);
    #2 if (dly != 16'h0000) chk(integrating_out, 1'b0);
    wait_for(1'b1);
    if (drop) begin
      repeat (24) @(posedge sys_clk_in);
      #1 {cur_a_in, cur_b_in, cur_c_in} = 48'h0;
    end
    wait_for(1'b0);
    chk(drop ? nsamp < 30 : nsamp inside {[35:41]}, 1'b1);
    tot_chk();
  endtask
  task automatic wchk(input logic [39:0] th, input logic [15:0] bs, input logic e);
    @(posedge sys_clk_in);
    #1 {wear_thresh_in, block_in, wear_block_sel_in} = {th, bs};
    repeat (48) @(posedge sys_clk_in);
    #2 chk(wear_alarm_out, e);
  endtask
  task automatic tc(input logic [6:0] s);
    @(posedge sys_clk_in);
    #1 {path_open, welded, stuck, trip_cmd_in, lockout_tripped_in, lockout_sup_in, block_in[1]} = s;
    repeat (64) @(posedge sys_clk_in);
    #2;
  endtask
  always #10 sys_clk_in = ~sys_clk_in;
  always begin
    repeat (3) @(posedge sys_clk_in);
    #1 sample_in = 1'b1;
    @(posedge sys_clk_in);
    #1 sample_in = 1'b0;
  end
  // Reference totals follow every sample the design takes
  always @(posedge sys_clk_in) begin
    if (sample_in && integrating_out) begin
      nsamp++;
      exp_tot[0] += wear(cur_a_in);
      exp_tot[1] += wear(cur_b_in);
      exp_tot[2] += wear(cur_c_in);
    end
    if (preset_load_in) exp_tot = '{clampf(preset_a_in), clampf(preset_b_in), clampf(preset_c_in)};
  end
  initial begin
    repeat (4) @(posedge sys_clk_in);
    #1 reset_in = 1'b0;
    tot_chk();
    @(posedge sys_clk_in);
    #1 lfsr = nx(lfsr);
    {preset_a_in, preset_b_in, preset_c_in} = {lfsr, 24'h0, BWM_PRESET_MAX, 24'h0, lfsr};
    preset_load_in = 1'b1;
    @(posedge sys_clk_in);
    #1 preset_load_in = 1'b0;
    tot_chk();
    run(1'b0, 16'h0000, 1'b0);
    run(1'b1, 16'h0005, 1'b1);
    foreach (exp_tot[k]) if (exp_tot[k] > mx) mx = exp_tot[k];
    wchk(40'(mx - 1), 16'h0001, 1'b1);
    wchk(40'(mx), 16'h0001, 1'b0);
    wchk(40'(mx - 1), 16'h0101, 1'b0);
    wchk(40'(mx - 1), 16'h0402, 1'b1);
    foreach (tcs[k]) begin
      tc(tcs[k][9:3]);
      chk({tc_open_out, tc_noclose_out, tc_alarm_out}, tcs[k][2:0]);
    end
    tc(7'h43);
    chk(tc_alarm_out, 1'b0);
    tc(7'h02);
    // Faults shorter than the delay must never build up an alarm
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk_in);
      #1 path_open = ~path_open;
      repeat (15) @(posedge sys_clk_in);
      #2 chk(tc_alarm_out, 1'b0);
    end
    test_done();
  end
endmodule
